// ===== src/two_level_interrupt_ctrl.sv
// Two-level interrupt controller with an APB register slave.
// Assumes the core takes vector_take as an interrupt entry in the same
// cycle and pulses the return strobe when it leaves a service routine.
`timescale 1ns/1ns

// Function
// - High vector 0008h, low vector 0018h
// - High request preempts running low routine
// - Each source has flag, enable, priority
// - Mode bit clear ignores priority selects
// - In compatibility mode peripherals need peripheral and global enable
// - Global enable gates all sources
// - Compatibility mode always vectors to 0008h
// - High-level enable admits high-priority sources
// - Low enable admits low sources with high
// - Flag, enable, global enable vector at once
// - Acceptance clears the relevant global enable
// - No low service during high routine
// - Core pushes return, loads vector address
// - Return instruction re-sets the global enable
// - External event latency three to four cycles
// - Flags set regardless of any enable
// - High enable clear blocks every source
// - Edge select one rising, zero falling
module two_level_interrupt_ctrl
(
  // Clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 reset_n,
  // APB slave
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [31:0]                          pwdata,
  output logic [31:0]                               prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  // Interrupt sources
  input  wire logic [irq_ctrl_pkg::NUM_EXT-1:0]     ext_pin,
  input  wire logic [irq_ctrl_pkg::PORT_W-1:0]      port_pins,
  input  wire logic [irq_ctrl_pkg::NUM_PERIPH-1:0]  periph_event,
  // Core side
  input  wire logic                                 return_from_service_instr,
  output logic                                      vector_take,
  output logic [15:0]                               vector_addr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  irq_ctrl_pkg::ctrl_state_t s_r;
  irq_ctrl_pkg::ctrl_state_t s_nxt;

  logic [irq_ctrl_pkg::NUM_SRC-1:0] ev;
  logic [irq_ctrl_pkg::NUM_SRC-1:0] act;
  logic [irq_ctrl_pkg::NUM_SRC-1:0] w1c;
  logic                             setup;
  logic                             wr;
  logic                             hit;
  logic                             hi_req;
  logic                             lo_req;
  logic                             cmp_req;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;

    // Pins pass two flops before the edge logic looks at them
    s_nxt.sync1 = {port_pins, ext_pin};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev  = s_r.sync2;

    ev = '0;
    for (int i = 0; i < irq_ctrl_pkg::NUM_EXT; i++)
    begin
      ev[i] = s_r.ext_pin_edge_select[i]
            ? (s_r.sync2[i] & ~s_r.prev[i])
            : (~s_r.sync2[i] & s_r.prev[i]);
    end
    ev[irq_ctrl_pkg::PORT_SRC] =
      |(s_r.sync2[irq_ctrl_pkg::SYNC_W-1:irq_ctrl_pkg::NUM_EXT]
        ^ s_r.prev[irq_ctrl_pkg::SYNC_W-1:irq_ctrl_pkg::NUM_EXT]);
    ev[irq_ctrl_pkg::NUM_SRC-1:irq_ctrl_pkg::FIRST_PERIPH] = periph_event;

    // APB decode; the slave answers in the first access cycle
    setup = psel & ~penable;
    wr    = psel & penable & s_r.ready & pwrite & ~s_r.err;
    hit   = (paddr == irq_ctrl_pkg::CTRL_OFS)
          | (paddr == irq_ctrl_pkg::FLAG_OFS)
          | (paddr == irq_ctrl_pkg::EN_OFS)
          | (paddr == irq_ctrl_pkg::PRIO_OFS)
          | (paddr == irq_ctrl_pkg::STAT_OFS);
    s_nxt.ready = setup;
    s_nxt.err   = setup & ~hit;

    if (setup)
    begin
      s_nxt.rdata = '0;
      unique case (paddr)
        irq_ctrl_pkg::CTRL_OFS:
        begin
          s_nxt.rdata[irq_ctrl_pkg::CTRL_HIGH_LEVEL_GLOBAL_ENABLE_BIT] =
            s_r.high_level_global_enable;
          s_nxt.rdata[irq_ctrl_pkg::CTRL_LOW_LEVEL_GLOBAL_ENABLE_BIT] =
            s_r.low_level_global_enable;
          s_nxt.rdata[irq_ctrl_pkg::CTRL_MODE_BIT] =
            s_r.priority_mode_enable;
          s_nxt.rdata[irq_ctrl_pkg::CTRL_EDGE_LSB +: irq_ctrl_pkg::NUM_EXT] =
            s_r.ext_pin_edge_select;
        end
        irq_ctrl_pkg::FLAG_OFS:
          s_nxt.rdata[irq_ctrl_pkg::NUM_SRC-1:0] = s_r.flags;
        irq_ctrl_pkg::EN_OFS:
          s_nxt.rdata[irq_ctrl_pkg::NUM_SRC-1:0] = s_r.enable;
        irq_ctrl_pkg::PRIO_OFS:
          s_nxt.rdata[irq_ctrl_pkg::NUM_SRC-1:0] = s_r.prio;
        irq_ctrl_pkg::STAT_OFS:
        begin
          s_nxt.rdata[irq_ctrl_pkg::STAT_SVCH_BIT] = s_r.svc_high;
          s_nxt.rdata[irq_ctrl_pkg::STAT_SVCL_BIT] = s_r.svc_low;
          s_nxt.rdata[irq_ctrl_pkg::STAT_VEC_LSB +: 16] = s_r.vec;
        end
        default:
          s_nxt.rdata = '0;
      endcase
    end

    // Flags: write one to clear, a new event wins over the clear
    w1c = '0;
    if (wr && paddr == irq_ctrl_pkg::FLAG_OFS)
      w1c = pwdata[irq_ctrl_pkg::NUM_SRC-1:0];
    s_nxt.flags = (s_r.flags & ~w1c) | ev;

    if (wr && paddr == irq_ctrl_pkg::EN_OFS)
      s_nxt.enable = pwdata[irq_ctrl_pkg::NUM_SRC-1:0];
    if (wr && paddr == irq_ctrl_pkg::PRIO_OFS)
      s_nxt.prio = pwdata[irq_ctrl_pkg::NUM_SRC-1:0];
    if (wr && paddr == irq_ctrl_pkg::CTRL_OFS)
    begin
      s_nxt.high_level_global_enable =
        pwdata[irq_ctrl_pkg::CTRL_HIGH_LEVEL_GLOBAL_ENABLE_BIT];
      s_nxt.low_level_global_enable =
        pwdata[irq_ctrl_pkg::CTRL_LOW_LEVEL_GLOBAL_ENABLE_BIT];
      s_nxt.priority_mode_enable = pwdata[irq_ctrl_pkg::CTRL_MODE_BIT];
      s_nxt.ext_pin_edge_select =
        pwdata[irq_ctrl_pkg::CTRL_EDGE_LSB +: irq_ctrl_pkg::NUM_EXT];
    end

    // Return from a service routine
    if (return_from_service_instr)
    begin
      if (!s_r.priority_mode_enable)
        s_nxt.high_level_global_enable = 1'b1;
      else if (s_r.svc_high)
      begin
        s_nxt.high_level_global_enable = 1'b1;
        s_nxt.svc_high = 1'b0;
      end
      else if (s_r.svc_low)
      begin
        s_nxt.low_level_global_enable = 1'b1;
        s_nxt.svc_low = 1'b0;
      end
      else
        s_nxt.high_level_global_enable = 1'b1;
    end

    // Acceptance, decided from the settled state of this cycle
    act     = s_r.flags & s_r.enable;
    cmp_req = s_r.high_level_global_enable
            & |(act & (~irq_ctrl_pkg::PERIPH_MASK
                | {irq_ctrl_pkg::NUM_SRC{s_r.low_level_global_enable}}));
    hi_req  = s_r.high_level_global_enable & |(act & s_r.prio);
    lo_req  = s_r.high_level_global_enable
            & s_r.low_level_global_enable
            & ~s_r.svc_high
            & |(act & ~s_r.prio);

    s_nxt.take = 1'b0;
    if (!s_r.priority_mode_enable)
    begin
      if (cmp_req)
      begin
        s_nxt.take = 1'b1;
        s_nxt.vec  = irq_ctrl_pkg::VEC_HIGH;
        s_nxt.high_level_global_enable = 1'b0;
      end
    end
    else if (hi_req)
    begin
      // Preempts a low routine: the low-level enable is untouched
      s_nxt.take     = 1'b1;
      s_nxt.vec      = irq_ctrl_pkg::VEC_HIGH;
      s_nxt.svc_high = 1'b1;
      s_nxt.high_level_global_enable = 1'b0;
    end
    else if (lo_req)
    begin
      s_nxt.take    = 1'b1;
      s_nxt.vec     = irq_ctrl_pkg::VEC_LOW;
      s_nxt.svc_low = 1'b1;
      s_nxt.low_level_global_enable = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_r                     <= '0;
      s_r.prio                <= irq_ctrl_pkg::PRIO_RST;
      s_r.ext_pin_edge_select <= irq_ctrl_pkg::EDGE_RST;
      s_r.vec                 <= irq_ctrl_pkg::VEC_RST;
    end
    else
      s_r <= s_nxt;
  end

  // Event to vector: two sync flops, flag, take; the edge compare adds no flop
  assign prdata      = s_r.rdata;
  assign pready      = s_r.ready;
  assign pslverr     = s_r.err;
  assign vector_take = s_r.take;
  assign vector_addr = s_r.vec;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  vec_range_a: assert property (
    vector_take |-> (vector_addr == irq_ctrl_pkg::VEC_HIGH
                     || vector_addr == irq_ctrl_pkg::VEC_LOW))
    else $error("vector outside the two vectors");

  compat_vec_a: assert property (
    vector_take && !$past(s_r.priority_mode_enable)
      |-> vector_addr == irq_ctrl_pkg::VEC_HIGH)
    else $error("compatibility entry not at high vector");

  accept_clear_a: assert property (
    vector_take |-> (vector_addr == irq_ctrl_pkg::VEC_HIGH
                     ? !s_r.high_level_global_enable
                     : !s_r.low_level_global_enable))
    else $error("global enable left set on entry");

  no_low_high_a: assert property (
    vector_take && vector_addr == irq_ctrl_pkg::VEC_LOW
      |-> !$past(s_r.svc_high))
    else $error("low entry during high routine");

  flag_set_a: assert property (
    periph_event != '0
      |=> (s_r.flags[irq_ctrl_pkg::NUM_SRC-1:irq_ctrl_pkg::FIRST_PERIPH]
           & $past(periph_event)) == $past(periph_event))
    else $error("peripheral event did not set its flag");

  high_preempt_a: assert property (
    s_r.priority_mode_enable && s_r.svc_low
      && s_r.high_level_global_enable
      && |(s_r.flags & s_r.enable & s_r.prio)
      |=> vector_take && vector_addr == irq_ctrl_pkg::VEC_HIGH)
    else $error("high request did not preempt low routine");

  ret_level_a: assert property (
    return_from_service_instr && s_r.priority_mode_enable && s_r.svc_high
      |=> (s_r.high_level_global_enable && !s_r.svc_high
           && s_r.low_level_global_enable
              == $past(s_r.low_level_global_enable)) || vector_take)
    else $error("return restored the wrong level");

  gie_block_a: assert property (
    !s_r.high_level_global_enable |=> !vector_take)
    else $error("entry with global enable clear");

  periph_block_a: assert property (
    !s_r.priority_mode_enable && !s_r.low_level_global_enable
      && (s_r.flags & s_r.enable & ~irq_ctrl_pkg::PERIPH_MASK) == '0
      |=> !vector_take)
    else $error("peripheral taken with peripheral enable clear");

  vector_now_a: assert property (
    !s_r.priority_mode_enable && s_r.high_level_global_enable
      && |(s_r.flags & s_r.enable & ~irq_ctrl_pkg::PERIPH_MASK)
      |=> vector_take)
    else $error("enabled request not vectored at once");

  pin_latency_a: assert property (
    $rose(s_r.sync2[0]) && s_r.ext_pin_edge_select[0]
      && s_r.enable[0] && !s_r.flags[0]
      |=> s_r.flags[0])
    else $error("pin edge flag late");

endmodule : two_level_interrupt_ctrl

// ===== inc/irq_ctrl_pkg.sv
// Constants, register map and state layout of the interrupt controller.
// Assumes one clock that is the core's instruction-cycle clock.
package irq_ctrl_pkg;

  // ----------------------------------------------------------------
  // Source layout
  // ----------------------------------------------------------------
  localparam int NUM_EXT      = 3;
  localparam int PORT_W       = 8;
  localparam int NUM_PERIPH   = 8;
  localparam int PORT_SRC     = NUM_EXT;
  localparam int FIRST_PERIPH = NUM_EXT + 1;
  localparam int NUM_SRC      = FIRST_PERIPH + NUM_PERIPH;
  localparam int SYNC_W       = NUM_EXT + PORT_W;
  localparam logic [NUM_SRC-1:0] PERIPH_MASK = 12'hFF0;

  // ----------------------------------------------------------------
  // Vectors
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW  = 16'h0018;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W   = 8;
  localparam logic [7:0]  CTRL_OFS = 8'h00;
  localparam logic [7:0]  FLAG_OFS = 8'h04;
  localparam logic [7:0]  EN_OFS   = 8'h08;
  localparam logic [7:0]  PRIO_OFS = 8'h0C;
  localparam logic [7:0]  STAT_OFS = 8'h10;

  localparam int CTRL_HIGH_LEVEL_GLOBAL_ENABLE_BIT = 0;
  localparam int CTRL_LOW_LEVEL_GLOBAL_ENABLE_BIT = 1;
  localparam int CTRL_MODE_BIT = 2;
  localparam int CTRL_EDGE_LSB = 4;
  localparam int STAT_SVCH_BIT = 0;
  localparam int STAT_SVCL_BIT = 1;
  localparam int STAT_VEC_LSB  = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_SRC-1:0] PRIO_RST = 12'hFFF;
  localparam logic [NUM_EXT-1:0] EDGE_RST = 3'h7;
  localparam logic [15:0]        VEC_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // State of the controller
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SYNC_W-1:0]  sync1;
    logic [SYNC_W-1:0]  sync2;
    logic [SYNC_W-1:0]  prev;
    logic [NUM_SRC-1:0] flags;
    logic [NUM_SRC-1:0] enable;
    logic [NUM_SRC-1:0] prio;
    logic               high_level_global_enable;
    logic               low_level_global_enable;
    logic               priority_mode_enable;
    logic [NUM_EXT-1:0] ext_pin_edge_select;
    logic               svc_high;
    logic               svc_low;
    logic               take;
    logic [15:0]        vec;
    logic [31:0]        rdata;
    logic               ready;
    logic               err;
  } ctrl_state_t;

endpackage : irq_ctrl_pkg

// ===== verification/core_model.sv
// Core-side partner: stacks entry vector addresses, issues return pulses.
// Assumes vector_take is a one-cycle pulse on clk.
`timescale 1ns/1ns
module core_model
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Controller side
  input  wire logic        vector_take,
  input  wire logic [15:0] vector_addr,
  output logic             return_from_service_instr,
  output int               depth
);
  logic [15:0] stack_q[$];

  initial
  begin
    return_from_service_instr = 1'b0;
    depth = 0;
  end

  // Entry pushes the vector address onto the stack
  always @(posedge clk)
  begin
    if (reset_n && vector_take === 1'b1)
    begin
      stack_q.push_back(vector_addr);
      depth = stack_q.size();
    end
  end

  // Caller clears the flags first, else the routine is re-entered
  task automatic ret();
  begin
    @(posedge clk);
    return_from_service_instr <= 1'b1;
    @(posedge clk);
    return_from_service_instr <= 1'b0;
    if (stack_q.size() > 0)
      void'(stack_q.pop_back());
    depth = stack_q.size();
  end
  endtask : ret
endmodule : core_model

// ===== verification/testbench.sv
// Self-checking bench for the two-level interrupt controller.
// Assumes the core model answers entries and returns on command.
`timescale 1ns/1ns
module testbench;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam logic [7:0] CT = irq_ctrl_pkg::CTRL_OFS;
  localparam logic [7:0] FL = irq_ctrl_pkg::FLAG_OFS;
  localparam logic [7:0] EN = irq_ctrl_pkg::EN_OFS;
  localparam logic [7:0] PR = irq_ctrl_pkg::PRIO_OFS;
  localparam logic [7:0] ST = irq_ctrl_pkg::STAT_OFS;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  ext_pin;
  logic [7:0]  port_pins;
  logic [7:0]  periph_event;
  logic        return_from_service_instr;
  logic        vector_take;
  logic [15:0] vector_addr;
  logic [15:0] exp_q[$];
  logic [15:0] mon_e;
  logic [31:0] rd;
  logic        er;
  logic [31:0] lfsr = 32'hDFEE;
  int          depth;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  int          take_cyc = 0;
  int          drv_cyc = 0;

  always #5 clk = ~clk;

  two_level_interrupt_ctrl dut (.clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_pin, .port_pins,
    .periph_event, .return_from_service_instr, .vector_take, .vector_addr);
  core_model core (.clk, .reset_n, .vector_take, .vector_addr,
    .return_from_service_instr, .depth);

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
  begin
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask : chk

  task automatic tally_and_finish();
  begin
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask : tally_and_finish

  // Request held until pready is sampled high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
  begin
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask : apb

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(logic [7:0] a, logic [31:0] exp, string nm);
  begin
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  end
  endtask : rdc

  // Argument is the source number, not the event pin number
  task automatic pev(int i);
  begin
    @(posedge clk);
    periph_event <= 8'h01 << (i - irq_ctrl_pkg::FIRST_PERIPH);
    @(posedge clk);
    periph_event <= 8'h00;
  end
  endtask : pev

  // Waits until the monitor has consumed every expected entry
  task automatic drain();
    int n;
  begin
    n = 0;
    while (exp_q.size() > 0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (exp_q.size() > 0)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  endtask : drain

  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // ------------------------------------------------------------
  // Monitor
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (vector_take === 1'b1)
    begin
      take_cyc = cyc;
      if (exp_q.size() == 0)
        chk("vector_take", 32'h1, 32'h0);
      else
      begin
        mon_e = exp_q.pop_front();
        chk("vector_addr", {16'h0, vector_addr}, {16'h0, mon_e});
      end
    end
  end

  // Hang guard
  initial
  begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    psel         <= 1'b0;
    penable      <= 1'b0;
    pwrite       <= 1'b0;
    paddr        <= 8'h00;
    pwdata       <= 32'h0;
    ext_pin      <= 3'h0;
    port_pins    <= 8'h00;
    periph_event <= 8'h00;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rdc(CT, 32'h70, "ctrl");
    rdc(FL, 32'h0, "flag");
    rdc(EN, 32'h0, "enable");
    rdc(PR, 32'hFFF, "prio");
    rdc(ST, 32'h0, "stat");
    rdc(8'h14, 32'h0, "unmapped");
    chk("pslverr", {31'h0, er}, 32'h1);
    $display("test reset done");
    wr(EN, 32'hFFF);
    wr(PR, 32'h000);
    wr(CT, 32'h71);
    pev(4);
    idle(4);
    rdc(FL, 32'h010, "flag");
    wr(CT, 32'h72);
    idle(4);
    exp_q.push_back(16'h0008);
    wr(CT, 32'h73);
    drain();
    rdc(CT, 32'h72, "ctrl");
    wr(FL, 32'hFFF);
    core.ret();
    idle(2);
    rdc(CT, 32'h73, "ctrl");
    $display("test compat done");
    wr(CT, 32'h71);
    @(posedge clk);
    ext_pin <= 3'h1;
    drv_cyc = cyc;
    exp_q.push_back(16'h0008);
    drain();
    chk("latency", 32'(take_cyc - drv_cyc - 1 inside {3, 4}), 32'h1);
    wr(FL, 32'hFFF);
    core.ret();
    wr(CT, 32'h61);
    @(posedge clk);
    ext_pin <= 3'h0;
    exp_q.push_back(16'h0008);
    drain();
    wr(FL, 32'hFFF);
    core.ret();
    @(posedge clk);
    ext_pin <= 3'h1;
    idle(8);
    rdc(FL, 32'h0, "flag");
    lfsr = lfsr_next(lfsr);
    @(posedge clk);
    port_pins <= lfsr[7:0] | 8'h01;
    exp_q.push_back(16'h0008);
    drain();
    wr(FL, 32'hFFF);
    core.ret();
    $display("test pins done");
    wr(PR, 32'h020);
    wr(CT, 32'h77);
    exp_q.push_back(16'h0008);
    pev(5);
    drain();
    rdc(CT, 32'h76, "ctrl");
    pev(4);
    idle(6);
    wr(FL, 32'h020);
    exp_q.push_back(16'h0018);
    core.ret();
    drain();
    rdc(CT, 32'h75, "ctrl");
    exp_q.push_back(16'h0008);
    pev(5);
    drain();
    rdc(ST, 32'h00080003, "stat");
    chk("depth", 32'(depth), 32'h2);
    wr(FL, 32'h030);
    core.ret();
    rdc(CT, 32'h75, "ctrl");
    core.ret();
    rdc(CT, 32'h77, "ctrl");
    rdc(ST, 32'h00080000, "stat");
    wr(CT, 32'h75);
    pev(4);
    idle(6);
    exp_q.push_back(16'h0008);
    pev(5);
    drain();
    $display("test priority done");
    idle(4);
    chk("pending", 32'(exp_q.size()), 32'h0);
    tally_and_finish();
  end
endmodule : testbench
